// ### hdl/frc_pkg.sv
// constants, register map and state codes of the flash read cache controller
package frc_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_WAYS = 8'h04;
	localparam logic [7:0] OFS_LSIZE = 8'h08;
	localparam logic [7:0] OFS_CLEN = 8'h0C;
	localparam logic [7:0] OFS_REMAP = 8'h10;
	localparam logic [7:0] OFS_MINT = 8'h14;
	localparam logic [7:0] OFS_MTHR = 8'h18;
	localparam logic [7:0] OFS_HITS = 8'h1C;
	localparam logic [7:0] OFS_MISS = 8'h20;
	localparam logic [7:0] OFS_STAT = 8'h24;
	localparam int CTRL_FLUSH_BIT = 0;
	localparam int CTRL_ROUTE_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_IRQ_BIT = 1;
	localparam logic RST_ROUTE = 1'b0;
	localparam logic [1:0] RST_WAYS = 2'h2;
	localparam logic [1:0] RST_LSIZE = 2'h0;
	localparam logic [9:0] RST_CLEN = 10'h000;
	localparam logic [2:0] RST_REMAP = 3'h0;
	localparam logic [20:0] RST_MINT = 21'h000000;
	localparam logic [20:0] RST_MTHR = 21'h000000;
	localparam logic [1:0] WAYS_1 = 2'h0;
	localparam logic [1:0] WAYS_2 = 2'h1;
	localparam logic [1:0] WAYS_4 = 2'h2;
	localparam logic [1:0] LS_8 = 2'h0;
	localparam logic [1:0] LS_16 = 2'h1;
	localparam logic [1:0] LS_32 = 2'h2;
	localparam logic [1:0] TV_INV = 2'h0;
	localparam logic [1:0] TV_8 = 2'h1;
	localparam logic [1:0] TV_16 = 2'h2;
	localparam logic [1:0] TV_32 = 2'h3;
	localparam logic [2:0] REMAP_FLASH = 3'h1;
	localparam logic [2:0] REMAP_OTP = 3'h2;
	localparam logic [9:0] CLEN_MAX = 10'h200;
	localparam int BANKS = 4;
	localparam int ROWS = 512;
	localparam logic [8:0] ROW_LAST = 9'h1FF;
	localparam logic [3:0] MISS_REQ_DLY = 4'h3;
	localparam logic [3:0] DATA_RET_DLY = 4'h4;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MON_MAX_MS = 10;
	localparam int MON_MAX_CYC_DEF = MON_MAX_MS * 1000000 / CLK_PERIOD_NS;
	typedef enum logic [6:0] {
		ST_CLEAR = 7'h01,
		ST_IDLE = 7'h02,
		ST_HIT = 7'h04,
		ST_MDLY = 7'h08,
		ST_FILL = 7'h10,
		ST_CLAT = 7'h20,
		ST_BYP = 7'h40
	} frc_state_t;
endpackage

// ### hdl/frc_cache.sv
// flash read cache controller: tag/data store, fill engine, bypass, miss monitor, apb registers
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
// Functional notes
// - flush bit clears every tag while fetches are stalled, then stall releases itself.
// - with several ways and no empty way, the victim way comes from the lfsr value.
// - cacheable window starts at flash base, up to 32 MB, length in 64 kB steps.
// - data store is 16 kB and tag store fixed in size.
// - logical line size is 8, 16 or 32 bytes, set at run time.
// - associativity is 1, 2 or 4 ways, set at run time.
// - only reads allocate lines; writes never enter the cache.
// - same-line hit no wait, other-line hit one wait, miss longer, bypass ready one cycle after the flash word.
// - cache only when remap is 1 or 2, and for remap 1 only below length; else bypass.
// - route select zero forces bypass for every address.
// - cached length only applies when flash is remapped to zero.
// - way and line size writes apply at once, no flush, contents kept.
// - physical line is 8 bytes; 16 and 32 byte lines span 2 or 4.
// - new line size applies only to later fills; older lines stay valid.
// - tag entry 24 bits: zero, address bits, validity/size code.
// - four banks act as four ways, two pairs or one concatenated way.
// - empty ways fill from way 0 upward; random victim only when all full.
// - hardware reset restores defaults and sweeps the tag store clear.
// - fetches during tag sweep wait and are served afterwards.
// - software reset restarts the state machine and tags, keeps configuration.
// - miss monitor counts while active and interrupts at the miss threshold.
// - hit and miss tallies latch over a programmed cycle interval up to 10 ms.
// - flash request 3 cycles after miss; data 4 cycles after flash completes.
module frc_cache
	import frc_pkg::*;
#(
	parameter int unsigned MON_MAX_CYC = MON_MAX_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fetch_valid,
	input wire logic fetch_write,
	input wire logic [31:0] fetch_addr,
	output logic fetch_ready,
	output logic [31:0] fetch_rdata,
	output logic flash_req,
	output logic [31:0] flash_addr,
	output logic [3:0] flash_words,
	input wire logic flash_rvalid,
	input wire logic [31:0] flash_rdata,
	input wire logic flash_last,
	input wire logic software_reset_in,
	input wire logic system_active,
	output logic miss_irq,
	output logic tag_clear_busy
);
	frc_state_t state_q;
	logic [8:0] clr_row_q;
	logic flush_q, route_q;
	logic [1:0] ways_q, lsize_q;
	logic [9:0] clen_q;
	logic [2:0] remap_q;
	logic [20:0] mint_q, mthr_q;
	logic [15:0] lfsr_q;
	logic [31:0] lbuf_q [8];
	logic lb_valid_q, pend_q;
	logic [24:0] lb_addr_q;
	logic [1:0] lb_sz_q;
	logic [31:0] byp_data_q;
	logic byp_done_q;
	logic [24:0] m_addr_q;
	logic [1:0] m_sz_q, m_bank_q;
	logic [8:0] m_row0_q;
	logic [3:0] cnt_q;
	logic [2:0] fill_cnt_q;
	logic [20:0] mon_tmr_q, hit_cnt_q, miss_cnt_q, hit_tally_q, miss_tally_q;
	logic irq_q;
	logic [23:0] tag_mem [BANKS][ROWS];
	logic [63:0] data_mem [BANKS][ROWS];

	// bank that backs a given way for the current associativity
	function automatic logic [1:0] bank_sel(input logic [1:0] w, input logic [1:0] ways, input logic [31:0] a);
		logic [1:0] b;
		b = a[13:12];
		if (ways == WAYS_4) begin
			b = w;
		end else if (ways == WAYS_2) begin
			b = {w[0], a[12]};
		end
		return b;
	endfunction

	// line-offset mask for a validity/size code, over address bits 24:3
	function automatic logic [21:0] line_mask(input logic [1:0] tv);
		logic [21:0] m;
		m = 22'h3FFFFF;
		if (tv == TV_16) begin
			m = 22'h3FFFFE;
		end else if (tv == TV_32) begin
			m = 22'h3FFFFC;
		end
		return m;
	endfunction

	logic wr_en, rd_en, sw_clear, clear_done;
	logic cacheable, lb_hit, tag_hit, empty_found, in_idle_req;
	logic [1:0] hit_bank, hit_tv, empty_bank, vict_bank, nways_m1, fill_tv;
	logic [2:0] nphys_m1, word_off;
	logic [8:0] row, hit_row0;
	logic [24:0] line_base;
	logic hit_evt, miss_evt, mon_on, mon_end;
	logic [20:0] mon_len;

	assign wr_en = psel & penable & pwrite & clk_en & (paddr[31:8] == 24'h000000);
	assign rd_en = psel & penable & ~pwrite;
	assign row = fetch_addr[11:3];
	assign nways_m1 = (ways_q == WAYS_4) ? 2'h3 : (ways_q == WAYS_2) ? 2'h1 : 2'h0;
	assign sw_clear = software_reset_in | (flush_q & (state_q == ST_IDLE));
	assign clear_done = (state_q == ST_CLEAR) & (clr_row_q == ROW_LAST);
	assign tag_clear_busy = (state_q == ST_CLEAR);

	// bypass unless routed, remapped and inside the window; writes always pass through
	always_comb begin
		cacheable = route_q & ~fetch_write & (fetch_addr[31:25] == 7'h00);
		if ((remap_q != REMAP_FLASH) && (remap_q != REMAP_OTP)) begin
			cacheable = 1'b0;
		end
		if ((remap_q == REMAP_FLASH) && (fetch_addr[31:16] >= {6'h00, clen_q})) begin
			cacheable = 1'b0;
		end
	end

	assign lb_hit = lb_valid_q & cacheable &
		((fetch_addr[24:3] & line_mask(lb_sz_q)) == (lb_addr_q[24:3] & line_mask(lb_sz_q)));
	assign word_off = fetch_addr[4:2] & ((lb_sz_q == TV_32) ? 3'h7 : (lb_sz_q == TV_16) ? 3'h3 : 3'h1);
	assign fetch_rdata = byp_done_q ? byp_data_q : lbuf_q[word_off];
	assign in_idle_req = (state_q == ST_IDLE) & fetch_valid & ~byp_done_q & ~sw_clear;
	// a tag hit answers from the freshly loaded line buffer one cycle after lookup
	assign fetch_ready = byp_done_q |
		(((state_q == ST_IDLE) | (state_q == ST_HIT)) & fetch_valid & lb_hit & ~sw_clear);

	// parallel tag lookup over all active ways, plus first empty way
	always_comb begin
		logic [1:0] b;
		logic [23:0] e;
		b = 2'h0;
		e = 24'h000000;
		tag_hit = 1'b0;
		hit_bank = 2'h0;
		hit_tv = TV_INV;
		empty_found = 1'b0;
		empty_bank = 2'h0;
		for (int w = 0; w < BANKS; w++) begin
			if (w[1:0] <= nways_m1) begin
				b = bank_sel(w[1:0], ways_q, fetch_addr);
				e = tag_mem[b][row];
				if ((e[1:0] != TV_INV) && (e[22:2] == fetch_addr[24:4]) && !tag_hit) begin
					tag_hit = 1'b1;
					hit_bank = b;
					hit_tv = e[1:0];
				end
				if ((e[1:0] == TV_INV) && !empty_found) begin
					empty_found = 1'b1;
					empty_bank = b;
				end
			end
		end
	end

	assign vict_bank = empty_found ? empty_bank : bank_sel(lfsr_q[1:0] & nways_m1, ways_q, fetch_addr);
	assign fill_tv = (lsize_q == LS_32) ? TV_32 : (lsize_q == LS_16) ? TV_16 : TV_8;
	assign nphys_m1 = (lsize_q == LS_32) ? 3'h3 : (lsize_q == LS_16) ? 3'h1 : 3'h0;
	assign line_base = {fetch_addr[24:5], fetch_addr[4:3] & ~nphys_m1[1:0], 3'h0};
	assign hit_row0 = row & ~((hit_tv == TV_32) ? 9'h003 : (hit_tv == TV_16) ? 9'h001 : 9'h000);

	// lfsr x^16+x^14+x^13+x^11, never passes through zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr_q <= LFSR_SEED;
		end else if (clk_en) begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		end
	end

	// control state machine; hardware reset starts with a tag sweep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_CLEAR;
			clr_row_q <= 9'h000;
			cnt_q <= 4'h0;
			fill_cnt_q <= 3'h0;
			flash_req <= 1'b0;
			flash_addr <= 32'h00000000;
			flash_words <= 4'h0;
			m_addr_q <= 25'h0000000;
			m_sz_q <= TV_8;
			m_bank_q <= 2'h0;
			m_row0_q <= 9'h000;
			byp_done_q <= 1'b0;
			byp_data_q <= 32'h00000000;
			pend_q <= 1'b0;
		end else if (clk_en) begin
			flash_req <= 1'b0;
			byp_done_q <= 1'b0;
			if (software_reset_in) begin
				state_q <= ST_CLEAR;
				clr_row_q <= 9'h000;
				pend_q <= 1'b0;
			end else begin
				case (state_q)
					ST_CLEAR: begin
						clr_row_q <= clr_row_q + 9'h001;
						if (clear_done) begin
							state_q <= ST_IDLE;
						end
					end
					ST_IDLE: begin
						if (fetch_ready) begin
							pend_q <= 1'b0;
						end
						if (flush_q) begin
							state_q <= ST_CLEAR;
							clr_row_q <= 9'h000;
						end else if (in_idle_req && !lb_hit) begin
							if (!cacheable) begin
								state_q <= ST_BYP;
								flash_req <= 1'b1;
								flash_addr <= {fetch_addr[31:2], 2'h0};
								flash_words <= 4'h1;
							end else if (tag_hit) begin
								state_q <= ST_HIT;
								pend_q <= 1'b1;
							end else begin
								state_q <= ST_MDLY;
								pend_q <= 1'b1;
								cnt_q <= 4'h1;
								m_addr_q <= line_base;
								m_sz_q <= fill_tv;
								m_bank_q <= vict_bank;
								m_row0_q <= line_base[11:3];
							end
						end
					end
					ST_HIT: begin
						state_q <= ST_IDLE;
						pend_q <= 1'b0;
					end
					ST_MDLY: begin
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == MISS_REQ_DLY - 4'h1) begin
							state_q <= ST_FILL;
							flash_req <= 1'b1;
							flash_addr <= {7'h00, m_addr_q};
							flash_words <= (m_sz_q == TV_32) ? 4'h8 : (m_sz_q == TV_16) ? 4'h4 : 4'h2;
							fill_cnt_q <= 3'h0;
						end
					end
					ST_FILL: begin
						if (flash_rvalid) begin
							fill_cnt_q <= fill_cnt_q + 3'h1;
							if (flash_last) begin
								state_q <= ST_CLAT;
								cnt_q <= 4'h1;
							end
						end
					end
					ST_CLAT: begin
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == DATA_RET_DLY - 4'h1) begin
							state_q <= ST_IDLE;
						end
					end
					ST_BYP: begin
						if (flash_rvalid) begin
							state_q <= ST_IDLE;
							byp_done_q <= 1'b1;
							byp_data_q <= flash_rdata;
						end
					end
					default: begin
						state_q <= ST_CLEAR;
						clr_row_q <= 9'h000;
					end
				endcase
			end
		end
	end

	// line buffer: serves same-line hits with no wait, reloaded on hits and fills
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lb_valid_q <= 1'b0;
			lb_addr_q <= 25'h0000000;
			lb_sz_q <= TV_8;
			for (int i = 0; i < 8; i++) begin
				lbuf_q[i] <= 32'h00000000;
			end
		end else if (clk_en) begin
			if (software_reset_in || (state_q == ST_CLEAR)) begin
				lb_valid_q <= 1'b0;
			end else if ((state_q == ST_IDLE) && in_idle_req && !lb_hit && cacheable) begin
				lb_valid_q <= tag_hit;
				lb_addr_q <= fetch_addr[24:0];
				lb_sz_q <= tag_hit ? hit_tv : fill_tv;
				for (int k = 0; k < 4; k++) begin
					lbuf_q[2 * k] <= data_mem[hit_bank][hit_row0 | k[8:0]][31:0];
					lbuf_q[2 * k + 1] <= data_mem[hit_bank][hit_row0 | k[8:0]][63:32];
				end
			end else if ((state_q == ST_FILL) && flash_rvalid) begin
				lbuf_q[fill_cnt_q] <= flash_rdata;
			end else if ((state_q == ST_CLAT) && (cnt_q == DATA_RET_DLY - 4'h1)) begin
				lb_valid_q <= 1'b1;
			end
		end
	end

	// data store, no reset: contents survive resizing and way changes
	always_ff @(posedge pclk) begin
		if (clk_en && (state_q == ST_FILL) && flash_rvalid) begin
			if (fill_cnt_q[0]) begin
				data_mem[m_bank_q][m_row0_q + {7'h00, fill_cnt_q[2:1]}][63:32] <= flash_rdata;
			end else begin
				data_mem[m_bank_q][m_row0_q + {7'h00, fill_cnt_q[2:1]}][31:0] <= flash_rdata;
			end
		end
	end

	// tag store: swept one row of all banks per cycle, written once the burst is complete
	always_ff @(posedge pclk) begin
		if (clk_en) begin
			if (state_q == ST_CLEAR) begin
				for (int b = 0; b < BANKS; b++) begin
					tag_mem[b][clr_row_q] <= 24'h000000;
				end
			end else if ((state_q == ST_FILL) && flash_rvalid && flash_last) begin
				for (int k = 0; k < 4; k++) begin
					if (k[2:0] <= ((m_sz_q == TV_32) ? 3'h3 : (m_sz_q == TV_16) ? 3'h1 : 3'h0)) begin
						tag_mem[m_bank_q][m_row0_q + k[8:0]] <=
							{1'b0, m_addr_q[24:4] | {20'h00000, k[1]}, m_sz_q};
					end
				end
			end
		end
	end

	// miss-rate monitor, idle while the system sleeps
	assign mon_on = system_active & (mint_q != 21'h000000);
	assign hit_evt = ((state_q == ST_IDLE) & in_idle_req & ~lb_hit & cacheable & tag_hit) |
		(fetch_ready & ~byp_done_q & ~pend_q);
	assign miss_evt = (state_q == ST_IDLE) & in_idle_req & ~lb_hit & cacheable & ~tag_hit;
	assign mon_len = (mint_q > MON_MAX_CYC[20:0]) ? MON_MAX_CYC[20:0] : mint_q;
	assign mon_end = mon_on & (mon_tmr_q >= mon_len - 21'h000001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mon_tmr_q <= 21'h000000;
			hit_cnt_q <= 21'h000000;
			miss_cnt_q <= 21'h000000;
			hit_tally_q <= 21'h000000;
			miss_tally_q <= 21'h000000;
		end else if (clk_en && mon_on) begin
			if (mon_end) begin
				mon_tmr_q <= 21'h000000;
				hit_tally_q <= hit_cnt_q + {20'h00000, hit_evt};
				miss_tally_q <= miss_cnt_q + {20'h00000, miss_evt};
				hit_cnt_q <= 21'h000000;
				miss_cnt_q <= 21'h000000;
			end else begin
				mon_tmr_q <= mon_tmr_q + 21'h000001;
				hit_cnt_q <= hit_cnt_q + {20'h00000, hit_evt};
				miss_cnt_q <= miss_cnt_q + {20'h00000, miss_evt};
			end
		end
	end

	// threshold flag; a new crossing wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else if (clk_en) begin
			if (mon_on && miss_evt && (mthr_q != 21'h000000) && (miss_cnt_q + 21'h000001 == mthr_q)) begin
				irq_q <= 1'b1;
			end else if (wr_en && (paddr[7:0] == OFS_STAT) && pwdata[STAT_IRQ_BIT]) begin
				irq_q <= 1'b0;
			end
		end
	end
	assign miss_irq = irq_q;

	// configuration registers: only the hardware reset touches them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flush_q <= 1'b0;
			route_q <= RST_ROUTE;
			ways_q <= RST_WAYS;
			lsize_q <= RST_LSIZE;
			clen_q <= RST_CLEN;
			remap_q <= RST_REMAP;
			mint_q <= RST_MINT;
			mthr_q <= RST_MTHR;
		end else if (clk_en) begin
			if (wr_en && (paddr[7:0] == OFS_CTRL)) begin
				flush_q <= pwdata[CTRL_FLUSH_BIT] | flush_q;
				route_q <= pwdata[CTRL_ROUTE_BIT];
			end else if ((state_q == ST_IDLE) && flush_q) begin
				flush_q <= 1'b0;
			end
			if (wr_en && (paddr[7:0] == OFS_WAYS) && (pwdata[1:0] != 2'h3)) begin
				ways_q <= pwdata[1:0];
			end
			if (wr_en && (paddr[7:0] == OFS_LSIZE) && (pwdata[1:0] != 2'h3)) begin
				lsize_q <= pwdata[1:0];
			end
			if (wr_en && (paddr[7:0] == OFS_CLEN)) begin
				clen_q <= (pwdata[9:0] > CLEN_MAX) ? CLEN_MAX : pwdata[9:0];
			end
			if (wr_en && (paddr[7:0] == OFS_REMAP)) begin
				remap_q <= pwdata[2:0];
			end
			if (wr_en && (paddr[7:0] == OFS_MINT)) begin
				mint_q <= pwdata[20:0];
			end
			if (wr_en && (paddr[7:0] == OFS_MTHR)) begin
				mthr_q <= pwdata[20:0];
			end
		end
	end

	// apb read mux; zero-wait slave while clk_en is high, unmapped words answer with an error
	logic mapped;
	always_comb begin
		prdata = 32'h00000000;
		mapped = 1'b1;
		case (paddr[7:0])
			OFS_CTRL: prdata = {30'h00000000, route_q, flush_q};
			OFS_WAYS: prdata = {30'h00000000, ways_q};
			OFS_LSIZE: prdata = {30'h00000000, lsize_q};
			OFS_CLEN: prdata = {22'h000000, clen_q};
			OFS_REMAP: prdata = {29'h00000000, remap_q};
			OFS_MINT: prdata = {11'h000, mint_q};
			OFS_MTHR: prdata = {11'h000, mthr_q};
			OFS_HITS: prdata = {11'h000, hit_tally_q};
			OFS_MISS: prdata = {11'h000, miss_tally_q};
			OFS_STAT: prdata = {30'h00000000, irq_q, tag_clear_busy};
			default: mapped = 1'b0;
		endcase
		if (!rd_en || (paddr[31:8] != 24'h000000)) begin
			prdata = 32'h00000000;
		end
	end
	assign pready = clk_en;
	assign pslverr = psel & penable & (~mapped | (paddr[31:8] != 24'h000000));
endmodule

// ### tb/frc_cache_props.sv
// port checker for the flash read cache controller, bound to its top module
`timescale 1ns/1ns
module frc_cache_props
	import frc_pkg::*;
#(
	parameter int unsigned MON_MAX_CYC = MON_MAX_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic fetch_valid,
	input wire logic fetch_write,
	input wire logic [31:0] fetch_addr,
	input wire logic fetch_ready,
	input wire logic [31:0] fetch_rdata,
	input wire logic flash_req,
	input wire logic [31:0] flash_addr,
	input wire logic [3:0] flash_words,
	input wire logic flash_rvalid,
	input wire logic [31:0] flash_rdata,
	input wire logic flash_last,
	input wire logic software_reset_in,
	input wire logic system_active,
	input wire logic miss_irq,
	input wire logic tag_clear_busy
);
	logic [10:0] busy_cnt_q;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// saturating count, so a sweep that never ends is still seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_cnt_q <= 11'h000;
		end else if (!tag_clear_busy) begin
			busy_cnt_q <= 11'h000;
		end else if (busy_cnt_q != 11'h7FF) begin
			busy_cnt_q <= busy_cnt_q + 11'h001;
		end
	end
	AST_SWEEP_BOUND: assert property (busy_cnt_q <= 11'h208) else $error("tag sweep too long");
	AST_SWEEP_STALL: assert property (tag_clear_busy |-> !fetch_ready && !flash_req)
		else $error("fetch served during tag sweep");
	AST_SWRST: assert property (software_reset_in |=> tag_clear_busy) else $error("no sweep after soft reset");
	AST_MISS_REQ: assert property (flash_req && flash_words != 4'h1 |-> $past(fetch_valid, 3) &&
		(!$past(fetch_valid, 4) || $past(fetch_ready, 4)) && !$past(tag_clear_busy, 4))
		else $error("line request not three cycles after miss");
	AST_FILL_LAT: assert property (flash_rvalid && flash_last && flash_words != 4'h1 |->
		!fetch_ready [*4] ##1 fetch_ready) else $error("fill data not four cycles after last word");
	AST_BYP_LAT: assert property (flash_rvalid && flash_last && flash_words == 4'h1 |=> fetch_ready)
		else $error("bypass word not passed on at once");
	AST_BURST_LEN: assert property (flash_req |-> flash_words inside {4'h1, 4'h2, 4'h4, 4'h8})
		else $error("illegal burst length");
	AST_BURST_ALIGN: assert property (flash_req |-> (flash_addr[5:0] & ({flash_words, 2'b00} - 6'h01)) == 6'h00)
		else $error("burst start not aligned");
	AST_NO_WR_FILL: assert property (flash_req && fetch_write |-> flash_words == 4'h1)
		else $error("write access allocated a line");
	COV_FILL32: cover property (flash_req && flash_words == 4'h8);
	COV_WR_BYP: cover property (flash_req && fetch_write);
	COV_IRQ: cover property ($rose(miss_irq));
endmodule
bind frc_cache frc_cache_props #(.MON_MAX_CYC(MON_MAX_CYC)) i_frc_cache_props (.*);

// ### tb/frc_flash_model.sv
// flash controller stand-in answering line and word bursts
`timescale 1ns/1ns
module frc_flash_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic flash_req,
	input wire logic [31:0] flash_addr,
	input wire logic [3:0] flash_words,
	output logic flash_rvalid,
	output logic [31:0] flash_rdata,
	output logic flash_last
);
	logic [31:0] base;
	logic [3:0] cnt;
	function automatic logic [31:0] word_at(input logic [31:0] ad);
		return ad ^ {ad[15:0], ad[31:16]} ^ 32'h3C5A0F96;
	endfunction
	initial begin
		flash_rvalid = 1'b0;
		flash_last = 1'b0;
		flash_rdata = 32'h0;
		forever begin
			@(posedge pclk);
			// idle bus keeps changing so a stale word cannot pass for a fresh one
			flash_rdata <= ~flash_rdata;
			if (flash_req === 1'b1 && presetn === 1'b1) begin
				base = flash_addr;
				cnt = flash_words;
				for (int k = 0; k < int'(cnt); k++) begin
					repeat (slow ? 3 : 1) @(posedge pclk);
					flash_rvalid <= 1'b1;
					flash_rdata <= word_at(base + 32'(4 * k));
					flash_last <= (k == int'(cnt) - 1);
					@(posedge pclk);
					flash_rvalid <= 1'b0;
					flash_last <= 1'b0;
					flash_rdata <= ~flash_rdata;
				end
			end
		end
	end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the flash read cache controller
`timescale 1ns/1ns
module tb_top;
	import frc_pkg::*;
	logic pclk, presetn, clk_en, psel, penable, pwrite, fetch_valid, fetch_write, software_reset_in;
	logic system_active, slow, pready, pslverr, fetch_ready, flash_req, flash_rvalid, flash_last, miss_irq;
	logic tag_clear_busy, err;
	logic [31:0] paddr, pwdata, prdata, fetch_addr, fetch_rdata, flash_addr, flash_rdata, rd, a;
	logic [3:0] flash_words, last_words;
	int errors, cmp_count, nreq, seed;
	bit cached[int];
	frc_cache #(.MON_MAX_CYC(4000)) i_frc_cache (.*);
	frc_flash_model i_frc_flash_model (.*);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (flash_req === 1'b1) begin
			nreq++;
			last_words <= flash_words;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			errors++;
			end_of_test();
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h000000, ad};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		bound(n, 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
		apb(1'b0, ad, 32'h0);
		chk(rd, exp);
	endtask
	// words: 0 = hit with no flash request, else expected burst length
	task automatic fetch(input logic [31:0] fa, input logic w, input logic [3:0] words, input int lat_exp);
		int n0, lat;
		n0 = nreq;
		lat = 0;
		@(posedge pclk);
		fetch_valid <= 1'b1;
		fetch_addr <= fa;
		fetch_write <= w;
		@(negedge pclk);
		while (fetch_ready !== 1'b1 && lat < 2000) begin
			@(negedge pclk);
			lat++;
		end
		bound(lat, 2000);
		chk(fetch_rdata, i_frc_flash_model.word_at({fa[31:2], 2'b00}));
		@(posedge pclk);
		fetch_valid <= 1'b0;
		chk(32'(nreq - n0), (words != 4'h0) ? 32'h1 : 32'h0);
		if (words != 4'h0) chk({28'h0, last_words}, {28'h0, words});
		if (lat_exp >= 0) chk(32'(lat), 32'(lat_exp));
	endtask
	task automatic wait_sweep();
		int n;
		bit seen;
		n = 0;
		seen = 1'b0;
		while (n < 800 && !(seen && tag_clear_busy === 1'b0)) begin
			@(negedge pclk);
			seen = seen || tag_clear_busy === 1'b1;
			n++;
		end
		bound(n, 800);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, fetch_valid, fetch_write, software_reset_in, slow} = 8'h00;
		{clk_en, system_active} = 2'h3;
		{paddr, pwdata, fetch_addr} = 96'h0;
		errors = 0;
		cmp_count = 0;
		nreq = 0;
		seed = 32'h1490;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		fetch(32'h00000104, 1'b0, 4'h1, -1);
		rchk(OFS_WAYS, 32'(RST_WAYS));
		rchk(OFS_LSIZE, 32'(RST_LSIZE));
		rchk(OFS_CLEN, 32'(RST_CLEN));
		apb(1'b1, 8'h28, 32'hFFFFFFFF);
		chk({31'h0, err}, 32'h1);
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 4; i++) begin
				apb(1'b1, (j > 0) ? OFS_LSIZE : OFS_WAYS, 32'(i));
				rchk((j > 0) ? OFS_LSIZE : OFS_WAYS, 32'((i == 3) ? 2 : i));
			end
		end
		apb(1'b1, OFS_REMAP, 32'(REMAP_FLASH));
		apb(1'b1, OFS_CLEN, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h2);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFS_LSIZE, 32'(i));
			a = 32'(256 * (i + 1));
			fetch(a, 1'b0, 4'(2 << i), -1);
			fetch(a + 32'h4, 1'b0, 4'h0, 0);
			if (i > 0) fetch(32'h00000100, 1'b0, 4'h0, 1);
		end
		fetch(32'h0000FFE0, 1'b0, 4'h8, -1);
		fetch(32'h00010000, 1'b0, 4'h1, -1);
		for (int r = 0; r < 8; r++) begin
			apb(1'b1, OFS_REMAP, 32'(r));
			fetch(32'h00020000 + 32'(r * 256), 1'b0, (r == 2) ? 4'h8 : 4'h1, -1);
		end
		apb(1'b1, OFS_REMAP, 32'(REMAP_FLASH));
		apb(1'b1, OFS_CLEN, 32'h3FF);
		rchk(OFS_CLEN, 32'(CLEN_MAX));
		fetch(32'h01FFFFE0, 1'b0, 4'h8, -1);
		fetch(32'h00003000, 1'b1, 4'h1, -1);
		fetch(32'h00003000, 1'b0, 4'h8, -1);
		apb(1'b1, OFS_CTRL, 32'h0);
		fetch(32'h00003000, 1'b0, 4'h1, -1);
		apb(1'b1, OFS_CTRL, 32'h2);
		apb(1'b1, OFS_LSIZE, 32'(LS_8));
		fetch(32'h00003000, 1'b0, 4'h0, -1);
		apb(1'b1, OFS_CTRL, 32'h3);
		wait_sweep();
		fetch(32'h00003000, 1'b0, 4'h2, -1);
		@(posedge pclk);
		software_reset_in <= 1'b1;
		@(posedge pclk);
		software_reset_in <= 1'b0;
		wait_sweep();
		rchk(OFS_LSIZE, 32'(LS_8));
		fetch(32'h00003000, 1'b0, 4'h2, -1);
		apb(1'b1, OFS_LSIZE, 32'(LS_16));
		for (int i = 0; i < 24; i++) begin
			a = 32'h00000400 + (32'($random(seed)) & 32'h000003FC);
			slow <= 1'($random(seed));
			if (cached.exists(int'(a[31:4]))) begin
				fetch(a, 1'b0, 4'h0, -1);
			end else begin
				cached[int'(a[31:4])] = 1'b1;
				fetch(a, 1'b0, 4'h4, -1);
			end
		end
		apb(1'b1, OFS_MINT, 32'h00000FA0);
		apb(1'b1, OFS_MTHR, 32'h2);
		fetch(32'h00000900, 1'b0, 4'h4, -1);
		chk({31'h0, miss_irq}, 32'h0);
		fetch(32'h00000980, 1'b0, 4'h4, -1);
		chk({31'h0, miss_irq}, 32'h1);
		rchk(OFS_STAT, 32'h2);
		apb(1'b1, OFS_STAT, 32'h2);
		@(negedge pclk);
		chk({31'h0, miss_irq}, 32'h0);
		fetch(32'h00000984, 1'b0, 4'h0, 0);
		fetch(32'h00000900, 1'b0, 4'h0, 1);
		// misses while asleep must not reach the tallies
		system_active <= 1'b0;
		fetch(32'h00000A00, 1'b0, 4'h4, -1);
		system_active <= 1'b1;
		repeat (4000) @(posedge pclk);
		rchk(OFS_HITS, 32'h2);
		rchk(OFS_MISS, 32'h2);
		@(posedge pclk);
		clk_en <= 1'b0;
		@(negedge pclk);
		chk({31'h0, pready}, 32'h0);
		@(posedge pclk);
		clk_en <= 1'b1;
		end_of_test();
	end
endmodule
